/* File: iop_port_top.sv */
// Summary of operation
// - Eight-pin port is input only, no driver.
// - Reading input port returns live pin levels.
// - Input port alternate functions are always connected.
// - Input pins feed NMI, stop, trigger, interrupts.
// - Six-pin port, per-pin direction, bits 5..0 used.
// - Direction, function-select, alt-direction registers configure port.
// - Control mode gives timer and interrupt pin functions.
// - Bus pins become bus functions outside single-chip mode 0.
// - Function-select bit 1 means control; resets zero.
// - Alt-direction bits 3,0 pick timer input or output.
// - Read returns pin, latch or alternate output.
`timescale 1ns/10ps
`default_nettype none
`include "iop_regs.svh"

module iop_port_top (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic [31:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [7:0] reg_rdata_out,
  input wire logic [7:0] in_port_pins_in,
  input wire logic [5:0] bidir_pins_in,
  output logic [5:0] bidir_pins_out,
  output logic [5:0] bidir_pins_oe_out,
  input wire logic [1:0] op_mode_pins_in,
  input wire logic [1:0] timer_output_in,
  output logic nmi_request_out,
  output logic [1:0] timer_output_stop_in_out,
  output logic [1:0] converter_trigger_in_out,
  output logic [6:0] ext_irq_input_out,
  output logic [1:0] timer_count_input_out,
  output logic [1:0] count_direction_input_out,
  output logic [1:0] counter_clear_input_out,
  output logic [3:0] port1_ext_irq_input_out,
  output logic bus_pins_function_out
);

  localparam int SYNC_W = `IOP_IN_PINS + `IOP_IO_PINS + 2;

  iop_pkg::iop_state_t st_reg;
  iop_pkg::iop_state_t st_next;
  logic [7:0] in_sync;
  logic [5:0] io_sync;
  logic [1:0] mode_sync;
  logic [5:0] alt_is_out;
  logic [5:0] alt_val;
  logic [5:0] io_read;
  logic [7:0] read_mux;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  iop_pin_if #(.WIDTH(SYNC_W)) pin_bus ();

  assign pin_bus.raw = {op_mode_pins_in, bidir_pins_in, in_port_pins_in};

  iop_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_in(clk_in),
    .pins(pin_bus.sync_side)
  );

  assign in_sync = pin_bus.sync[7:0];
  assign io_sync = pin_bus.sync[13:8];
  assign mode_sync = pin_bus.sync[15:14];

  ////////////////////////////////////////////////////////////////////////
  // Input-only port alternates, never gated

  assign nmi_request_out = in_sync[0];
  assign timer_output_stop_in_out = in_sync[2:1];
  assign converter_trigger_in_out = in_sync[4:3];
  assign ext_irq_input_out = in_sync[7:1];

  ////////////////////////////////////////////////////////////////////////
  // Six-pin port alternates

  // Only pins 0 and 3 have an output alternate
  always_comb begin
    alt_is_out = 6'h00;
    alt_val = 6'h00;
    alt_is_out[`IOP_ALT_LO_BIT] = st_reg.alt_dir[0];
    alt_is_out[`IOP_ALT_HI_BIT] = st_reg.alt_dir[1];
    alt_val[`IOP_ALT_LO_BIT] = st_reg.alt_dir[0] & timer_output_in[0];
    alt_val[`IOP_ALT_HI_BIT] = st_reg.alt_dir[1] & timer_output_in[1];
  end

  // Timer count inputs only in control mode with alt-direction input; other control inputs need control mode only
  assign timer_count_input_out = {
    io_sync[3] & st_reg.func_sel[3] & ~st_reg.alt_dir[1],
    io_sync[0] & st_reg.func_sel[0] & ~st_reg.alt_dir[0]};
  assign count_direction_input_out = {io_sync[4] & st_reg.func_sel[4],
                                      io_sync[1] & st_reg.func_sel[1]};
  assign counter_clear_input_out = {io_sync[5] & st_reg.func_sel[5],
                                    io_sync[2] & st_reg.func_sel[2]};
  assign port1_ext_irq_input_out = {io_sync[5:4] & st_reg.func_sel[5:4],
                                    io_sync[2:1] & st_reg.func_sel[2:1]};

  ////////////////////////////////////////////////////////////////////////
  // Read path

  always_comb begin
    for (int i = 0; i < `IOP_IO_PINS; i++) begin
      if (st_reg.dir[i]) begin
        io_read[i] = io_sync[i];
      end else if (st_reg.func_sel[i]) begin
        io_read[i] = alt_val[i];
      end else begin
        io_read[i] = st_reg.latch[i];
      end
    end
  end

  always_comb begin
    case (reg_addr_in)
      `IOP_ADDR_IN_LEVELS: read_mux = in_sync;
      `IOP_ADDR_LATCH: read_mux = {`IOP_UNUSED_ZERO, io_read};
      `IOP_ADDR_DIR: read_mux = {`IOP_DIR_UNUSED, st_reg.dir};
      `IOP_ADDR_FUNC_SEL: read_mux = {`IOP_UNUSED_ZERO, st_reg.func_sel};
      `IOP_ADDR_ALT_DIR: read_mux = {4'h0, st_reg.alt_dir[1], 2'h0, st_reg.alt_dir[0]};
      default: read_mux = `IOP_RDATA_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State update

  always_comb begin
    st_next = st_reg;
    st_next.rdata = reg_read_in ? read_mux : `IOP_RDATA_IDLE;
    if (reg_write_in) begin
      case (reg_addr_in)
        `IOP_ADDR_LATCH: st_next.latch = reg_wdata_in[5:0];
        `IOP_ADDR_DIR: st_next.dir = reg_wdata_in[5:0];
        `IOP_ADDR_FUNC_SEL: st_next.func_sel = reg_wdata_in[5:0];
        `IOP_ADDR_ALT_DIR: st_next.alt_dir = {reg_wdata_in[`IOP_ALT_HI_BIT],
                                              reg_wdata_in[`IOP_ALT_LO_BIT]};
        // Input-only port has no writable latch
        default: st_next.latch = st_reg.latch;
      endcase
    end
    // Strap caught once, on the first edge after reset release
    if (!st_reg.captured) begin
      st_next.opmode = mode_sync;
      st_next.captured = 1'b1;
    end
    for (int i = 0; i < `IOP_IO_PINS; i++) begin
      if (st_reg.func_sel[i]) begin
        // Control mode drives only for a timer output alternate
        st_next.pin_oe[i] = alt_is_out[i];
        st_next.pin_out[i] = alt_val[i];
      end else begin
        st_next.pin_oe[i] = ~st_reg.dir[i];
        st_next.pin_out[i] = st_reg.latch[i];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      st_reg.latch <= `IOP_LATCH_RESET;
      st_reg.dir <= `IOP_DIR_RESET;
      st_reg.func_sel <= `IOP_FUNC_SEL_RESET;
      st_reg.alt_dir <= `IOP_ALT_DIR_RESET;
      st_reg.pin_out <= `IOP_LATCH_RESET;
      st_reg.pin_oe <= `IOP_LATCH_RESET;
      st_reg.rdata <= `IOP_RDATA_IDLE;
      st_reg.opmode <= `IOP_MODE_SINGLE_CHIP0;
      st_reg.captured <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata_out = st_reg.rdata;
  assign bidir_pins_out = st_reg.pin_out;
  assign bidir_pins_oe_out = st_reg.pin_oe;
  // Bus pins stay port inputs until the strap is known
  assign bus_pins_function_out = st_reg.captured &&
                                 (st_reg.opmode != `IOP_MODE_SINGLE_CHIP0);

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  a_in_port_read: assert property (
    reg_read_in && reg_addr_in == `IOP_ADDR_IN_LEVELS |=> reg_rdata_out == $past(in_sync))
    else $error("input port read mismatch");

  a_rdata_one_cycle: assert property (
    !reg_read_in |=> reg_rdata_out == `IOP_RDATA_IDLE)
    else $error("read data outside its cycle");

  a_input_no_drive: assert property (
    1'b1 |=> (bidir_pins_oe_out & $past(st_reg.dir) & ~$past(st_reg.func_sel)) == 6'h00)
    else $error("input pin is driven");

  a_latch_driven: assert property (
    !st_reg.dir[2] && !st_reg.func_sel[2] |=>
      bidir_pins_oe_out[2] && bidir_pins_out[2] == $past(st_reg.latch[2]))
    else $error("output latch not on pin");

  a_alt_dir_ignored: assert property (
    !st_reg.func_sel[0] && st_reg.alt_dir[0] && !st_reg.dir[0] |=>
      bidir_pins_out[0] == $past(st_reg.latch[0]))
    else $error("alt direction acted in port mode");

  a_timer_out_pin: assert property (
    st_reg.func_sel[3] && st_reg.alt_dir[1] |=>
      bidir_pins_oe_out[3] && bidir_pins_out[3] == $past(timer_output_in[1]))
    else $error("timer output not on pin 3");

  a_reset_values: assert property (
    $past(reset_in) |-> st_reg.func_sel == `IOP_FUNC_SEL_RESET && st_reg.dir == `IOP_DIR_RESET)
    else $error("bad reset value");

  a_bidir_read: assert property (
    reg_read_in && reg_addr_in == `IOP_ADDR_LATCH && st_reg.dir == `IOP_DIR_RESET |=>
      reg_rdata_out == {2'h0, $past(io_sync)})
    else $error("bidir input read mismatch");

  a_bus_mode0: assert property (
    st_reg.opmode == `IOP_MODE_SINGLE_CHIP0 |-> !bus_pins_function_out)
    else $error("bus function in single-chip mode 0");

  a_irq_gated: assert property (
    !st_reg.func_sel[1] |-> !port1_ext_irq_input_out[0] && !count_direction_input_out[0])
    else $error("port-mode pin fed alternate input");

endmodule // iop_port_top

`default_nettype wire

/* File: iop_regs.svh */
`ifndef IOP_REGS_SVH
`define IOP_REGS_SVH

// Register addresses on the plain register port
`define IOP_ADDR_IN_LEVELS 32'hfffff400
`define IOP_ADDR_LATCH 32'hfffff402
`define IOP_ADDR_DIR 32'hfffff422
`define IOP_ADDR_FUNC_SEL 32'hfffff442
`define IOP_ADDR_ALT_DIR 32'hfffff462

// Reset values
`define IOP_LATCH_RESET 6'h00
`define IOP_DIR_RESET 6'h3f
`define IOP_FUNC_SEL_RESET 6'h00
`define IOP_ALT_DIR_RESET 2'h0
`define IOP_RDATA_IDLE 8'h00

// Field layout
`define IOP_IN_PINS 8
`define IOP_IO_PINS 6
`define IOP_ALT_LO_BIT 0
`define IOP_ALT_HI_BIT 3
`define IOP_DIR_UNUSED 2'h3
`define IOP_UNUSED_ZERO 2'h0

// Operating mode strap values
`define IOP_MODE_SINGLE_CHIP0 2'h0

`endif

/* File: iop_pkg.sv */
`default_nettype none

package iop_pkg;

  typedef struct packed {
    logic [5:0] latch;
    logic [5:0] dir;
    logic [5:0] func_sel;
    logic [1:0] alt_dir;
    logic [5:0] pin_out;
    logic [5:0] pin_oe;
    logic [7:0] rdata;
    logic [1:0] opmode;
    logic captured;
  } iop_state_t;

endpackage

`default_nettype wire

/* File: iop_pin_if.sv */
`timescale 1ns/10ps
`default_nettype none

interface iop_pin_if #(
  parameter int WIDTH = 16
);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;
  modport sync_side(input raw, output sync);
  modport user(output raw, input sync);
endinterface : iop_pin_if

`default_nettype wire

/* File: iop_sync.sv */
`timescale 1ns/10ps
`default_nettype none

module iop_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  iop_pin_if.sync_side pins
);

  typedef struct packed {
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s1;
  } iop_sync_state_t;

  iop_sync_state_t st_reg;
  iop_sync_state_t st_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("iop_sync: WIDTH must be at least 1");
    end
  endgenerate

  // First stage feeds only the second stage
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pins.raw;
    st_next.s2 = st_reg.s1;
  end

  // No reset: keeps sampling through reset so the strap is settled at release
  always_ff @(posedge clk_in) begin
    st_reg <= st_next;
  end

  assign pins.sync = st_reg.s2;

endmodule // iop_sync

`default_nettype wire

/* File: iop_pin_model.sv */
`timescale 1ns/10ps
`default_nettype none

module iop_pin_model (
  input wire logic [5:0] pin_out_in,
  input wire logic [5:0] pin_oe_in,
  input wire logic [5:0] ext_level_in,
  output logic [5:0] pin_level_out
);
  // Released pins take the outside level, never the last driven one
  assign pin_level_out = (pin_oe_in & pin_out_in) | (~pin_oe_in & ext_level_in);
endmodule // iop_pin_model

`default_nettype wire

/* File: input_port_and_six_bit_io_port_test.sv */
`timescale 1ns/10ps
`default_nettype none
`include "iop_regs.svh"

module input_port_and_six_bit_io_port_test;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [7:0] wdata = 8'h00, rdata, in_pins = 8'h00;
  logic wr = 1'b0, rd = 1'b0, nmi, busf;
  logic [5:0] ext = 6'h00, pins, pout, poe, latch, dir, func, eo, eout, p, q;
  logic [1:0] mode = 2'h0, tmr = 2'h0, alt, tci, cdi, cci, stop, trig, tin;
  logic [6:0] irq7;
  logic [3:0] irq4;
  int err_count = 0;
  int samples_checked = 0;
  integer seed = 32'h47b0;

  always #25 clk_in = ~clk_in;

  iop_port_top u_dut (.clk_in(clk_in), .reset_in(reset_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_write_in(wr), .reg_read_in(rd), .reg_rdata_out(rdata),
    .in_port_pins_in(in_pins), .bidir_pins_in(pins), .bidir_pins_out(pout),
    .bidir_pins_oe_out(poe), .op_mode_pins_in(mode), .timer_output_in(tmr),
    .nmi_request_out(nmi), .timer_output_stop_in_out(stop), .converter_trigger_in_out(trig),
    .ext_irq_input_out(irq7), .timer_count_input_out(tci), .count_direction_input_out(cdi),
    .counter_clear_input_out(cci), .port1_ext_irq_input_out(irq4),
    .bus_pins_function_out(busf));

  iop_pin_model u_pins (.pin_out_in(pout), .pin_oe_in(poe), .ext_level_in(ext),
    .pin_level_out(pins));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd_check(input logic [31:0] a, input logic [7:0] exp, input string name);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 check(name, exp, rdata);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic alt_out(input int b);
    alt_out = (b == 0) ? alt[0] & tmr[0] : (b == 3) ? alt[1] & tmr[1] : 1'b0;
  endfunction

  task automatic expect_pins();
    for (int b = 0; b < 6; b++) begin
      eo[b] = func[b] ? ((b == 0 && alt[0]) || (b == 3 && alt[1])) : ~dir[b];
      eout[b] = func[b] ? alt_out(b) : latch[b];
      p[b] = eo[b] ? eout[b] : ext[b];
      eout[b] = dir[b] ? p[b] : (func[b] ? alt_out(b) : latch[b]);
    end
    q = func & p;
    tin = {func[3] & ~alt[1] & p[3], func[0] & ~alt[0] & p[0]};
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1 check("oe after reset", 8'h00, {2'h0, poe});
    check("bus function mode0", 8'h00, {7'h0, busf});
    rd_check(`IOP_ADDR_DIR, 8'hff, "dir reset");
    rd_check(`IOP_ADDR_FUNC_SEL, 8'h00, "func reset");
    rd_check(`IOP_ADDR_ALT_DIR, 8'h00, "alt reset");
    @(posedge clk_in);
    ext <= 6'h2a;
    repeat (3) @(posedge clk_in);
    rd_check(`IOP_ADDR_LATCH, 8'h2a, "pin read reset");
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      latch = 6'($random(seed));
      dir = 6'($random(seed));
      func = (i < 2) ? 6'h00 : 6'($random(seed));
      alt = 2'($random(seed));
      @(posedge clk_in);
      ext <= 6'($random(seed));
      in_pins <= 8'($random(seed));
      tmr <= 2'($random(seed));
      wr_reg(`IOP_ADDR_LATCH, {2'h0, latch});
      wr_reg(`IOP_ADDR_DIR, {2'h3, dir});
      wr_reg(`IOP_ADDR_FUNC_SEL, {2'h0, func});
      wr_reg(`IOP_ADDR_ALT_DIR, {4'h0, alt[1], 2'h0, alt[0]});
      repeat (4) @(posedge clk_in);
      #1 expect_pins();
      check("oe", {2'h0, eo}, {2'h0, poe});
      check("out", {2'h0, eo & eout}, {2'h0, poe & pout});
      check("in alt", {3'h0, in_pins[4:0]}, {3'h0, trig, stop, nmi});
      check("ext irq", {1'h0, in_pins[7:1]}, {1'h0, irq7});
      check("tmr in", {6'h0, tin}, {6'h0, tci});
      check("ctl in", {q[5], q[4], q[2], q[1], q[5], q[2], q[4], q[1]}, {irq4, cci, cdi});
      rd_check(`IOP_ADDR_LATCH, {2'h0, eout}, "port read");
      rd_check(`IOP_ADDR_IN_LEVELS, in_pins, "input levels");
      rd_check(`IOP_ADDR_DIR, {2'h3, dir}, "dir read");
      rd_check(`IOP_ADDR_FUNC_SEL, {2'h0, func}, "func read");
      rd_check(`IOP_ADDR_ALT_DIR, {4'h0, alt[1], 2'h0, alt[0]}, "alt read");
    end
    $display("port test done");
    wr_reg(`IOP_ADDR_IN_LEVELS, ~in_pins);
    rd_check(`IOP_ADDR_IN_LEVELS, in_pins, "input port write");
    rd_check(32'hfffff404, 8'h00, "unmapped read");
    @(posedge clk_in);
    #1 check("rdata idle", 8'h00, rdata);
    $display("refusal test done");
    @(posedge clk_in);
    mode <= 2'h1;
    reset_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #1 check("bus function mode1", 8'h01, {7'h0, busf});
    check("oe after reset2", 8'h00, {2'h0, poe});
    $display("strap test done");
    complete_run();
  end

  initial begin
    repeat (2000) @(posedge clk_in);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule // input_port_and_six_bit_io_port_test

`default_nettype wire
